/* shared/nfp_pkg.sv */
`default_nettype none
package nfp_pkg;

   // ****************************************
   // NVM word indices and byte addresses
   // ****************************************
   localparam logic [7:0] IDX_FUNC_CTRL  = 8'h21;
   localparam logic [7:0] IDX_LAN_PWR    = 8'h22;
   localparam logic [7:0] IDX_FLASH_DET  = 8'h23;
   localparam logic [7:0] IDX_ALT_REV_32 = 8'h27;
   localparam logic [7:0] IDX_ALT_REV_1  = 8'h28;
   localparam logic [7:0] ADR_FUNC_CTRL  = 8'h84;
   localparam logic [7:0] ADR_LAN_PWR    = 8'h88;
   localparam logic [7:0] ADR_FLASH_DET  = 8'h8c;
   localparam logic [7:0] ADR_ALT_REV_32 = 8'h9c;
   localparam logic [7:0] ADR_ALT_REV_1  = 8'ha0;
   localparam logic [7:0] ADR_FUNC_STATE = 8'h00;
   localparam logic [7:0] ADR_REVISION   = 8'h04;
   localparam logic [7:0] ADR_PM_SELECT  = 8'h08;
   localparam logic [7:0] ADR_PM_DATA    = 8'h0c;
   localparam logic [7:0] ADR_CKSUM      = 8'h10;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int FC_IDE_EN    = 15;
   localparam int FC_SER_EN    = 14;
   localparam int FC_IPMI_EN   = 13;
   localparam int FC_LAN_SWAP  = 12;
   localparam int FC_IDE_INT   = 10;
   localparam int FC_SER_INT   = 8;
   localparam int FC_IPMI_INT  = 6;
   localparam int PW_D0        = 8;
   localparam int PW_COMMON    = 5;
   localparam int PW_D3        = 0;
   localparam int FD_CKSUM     = 15;
   localparam int FA_IDE       = 1;
   localparam int FA_SER       = 2;
   localparam int FA_IPMI      = 3;
   localparam int FA_LAN_SWAP  = 30;
   localparam int PS_FUNC      = 4;

   // ****************************************
   // Reset values, keys, data selects
   // ****************************************
   localparam logic [15:0] RST_FUNC_CTRL = 16'h0ec0;
   localparam logic [15:0] RST_LAN_PWR   = 16'h0000;
   localparam logic [15:0] RST_FLASH_DET = 16'h7fff;
   localparam logic [15:0] RST_ALT_REV   = 16'h0000;
   localparam logic [7:0]  RST_REV_KEY   = 8'h00;
   localparam logic [7:0]  KEY_ALT_3     = 8'h3d;
   localparam logic [7:0]  KEY_ALT_2     = 8'h2d;
   localparam logic [7:0]  KEY_ALT_1     = 8'h1d;
   localparam logic [3:0]  DS_D0_A       = 4'h0;
   localparam logic [3:0]  DS_D0_B       = 4'h4;
   localparam logic [3:0]  DS_D3_A       = 4'h3;
   localparam logic [3:0]  DS_D3_B       = 4'h7;
   localparam logic [3:0]  DS_COMMON     = 4'h8;

endpackage
`default_nettype wire

/* design/nfp_cfg_decode.sv */
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module nfp_cfg_decode #(
   parameter logic [7:0] BASE_REVISION = 8'h01 // Arbitrary value
) (
   input  wire logic        pclk,           // Core clock
   input  wire logic        presetn,        // Async reset, active low
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB enable
   input  wire logic        pwrite,         // APB direction
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error
   input  wire logic        nvm_load,       // Autoload word strobe
   input  wire logic [7:0]  nvm_addr,       // Autoload word index
   input  wire logic [15:0] nvm_data,       // Autoload word data
   input  wire logic        sig_valid,      // NVM signature valid
   input  wire logic        pm_enable,      // Power management enabled
   input  wire logic        lan_both_en,    // Both LAN ports enabled
   output logic             ide_visible,    // IDE config space shown
   output logic             serial_visible, // Serial config space shown
   output logic             ipmi_visible,   // IPMI config space shown
   output logic             lan0_func,      // PCI function of LAN 0
   output logic             lan1_func,      // PCI function of LAN 1
   output logic      [7:0]  ide_int_pin,    // IDE interrupt pin value
   output logic      [7:0]  serial_int_pin, // Serial interrupt pin value
   output logic      [7:0]  ipmi_int_pin,   // IPMI interrupt pin value
   output logic      [7:0]  pm_data         // PM data register value
);

   // ****************************************
   // Helpers
   // ****************************************
   // Interrupt Pin register: 1 = INTA .. 4 = INTD
   function automatic logic [7:0] int_pin(input logic [1:0] sel);
      int_pin = {6'h00, sel} + 8'h01;
   endfunction

   // ****************************************
   // Storage
   // ****************************************
   logic [15:0] func_ctrl;
   logic [15:0] lan_pwr;
   logic [14:0] flash_det;
   logic        cksum_valid;
   logic [15:0] alt_rev_32;
   logic [7:0]  alt_rev_1;
   logic [7:0]  rev_key;
   logic [3:0]  pm_select;
   logic        pm_func;
   logic [7:0]  next_pm_data;
   logic [31:0] next_prdata;
   logic        addr_ok;
   logic        bus_done;
   logic        bus_wr;
   logic [31:0] func_state;
   logic [7:0]  revision;
   logic        load_fc;

   assign bus_done = psel && penable && pready;
   assign bus_wr   = bus_done && pwrite;
   assign load_fc  = nvm_load && (nvm_addr == nfp_pkg::IDX_FUNC_CTRL);

   // ****************************************
   // Autoload of configuration words
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_ctrl  <= nfp_pkg::RST_FUNC_CTRL;
         lan_pwr    <= nfp_pkg::RST_LAN_PWR;
         flash_det  <= nfp_pkg::RST_FLASH_DET[14:0];
         alt_rev_32 <= nfp_pkg::RST_ALT_REV;
         alt_rev_1  <= nfp_pkg::RST_ALT_REV[15:8];
      end else if (nvm_load) begin
         unique case (nvm_addr)
            nfp_pkg::IDX_FUNC_CTRL:  func_ctrl  <= nvm_data;
            nfp_pkg::IDX_LAN_PWR:    lan_pwr    <= nvm_data;
            nfp_pkg::IDX_FLASH_DET:  flash_det  <= nvm_data[14:0];
            nfp_pkg::IDX_ALT_REV_32: alt_rev_32 <= nvm_data;
            nfp_pkg::IDX_ALT_REV_1:  alt_rev_1  <= nvm_data[15:8];
            default: ;
         endcase
      end
   end

   // Loaded value first, software sets it afterwards; set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cksum_valid <= nfp_pkg::RST_FLASH_DET[nfp_pkg::FD_CKSUM];
      end else if (bus_wr && paddr == nfp_pkg::ADR_CKSUM && pwdata[0]) begin
         cksum_valid <= 1'b1;
      end else if (nvm_load && nvm_addr == nfp_pkg::IDX_FLASH_DET) begin
         cksum_valid <= nvm_data[nfp_pkg::FD_CKSUM];
      end
   end

   // ****************************************
   // Function enables, routing, pins
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ide_visible    <= nfp_pkg::RST_FUNC_CTRL[nfp_pkg::FC_IDE_EN];
         serial_visible <= nfp_pkg::RST_FUNC_CTRL[nfp_pkg::FC_SER_EN];
         ipmi_visible   <= nfp_pkg::RST_FUNC_CTRL[nfp_pkg::FC_IPMI_EN];
         ide_int_pin    <= int_pin(nfp_pkg::RST_FUNC_CTRL[nfp_pkg::FC_IDE_INT +: 2]);
         serial_int_pin <= int_pin(nfp_pkg::RST_FUNC_CTRL[nfp_pkg::FC_SER_INT +: 2]);
         ipmi_int_pin   <= int_pin(nfp_pkg::RST_FUNC_CTRL[nfp_pkg::FC_IPMI_INT +: 2]);
      end else if (load_fc) begin
         ide_visible    <= nvm_data[nfp_pkg::FC_IDE_EN];
         serial_visible <= nvm_data[nfp_pkg::FC_SER_EN];
         ipmi_visible   <= nvm_data[nfp_pkg::FC_IPMI_EN];
         ide_int_pin    <= int_pin(nvm_data[nfp_pkg::FC_IDE_INT +: 2]);
         serial_int_pin <= int_pin(nvm_data[nfp_pkg::FC_SER_INT +: 2]);
         ipmi_int_pin   <= int_pin(nvm_data[nfp_pkg::FC_IPMI_INT +: 2]);
      end
   end

   // Routing follows the strap live; single LAN stays on function 0
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lan0_func <= 1'b0;
         lan1_func <= 1'b1;
      end else begin
         lan0_func <= lan_both_en && func_ctrl[nfp_pkg::FC_LAN_SWAP];
         lan1_func <= !(lan_both_en && func_ctrl[nfp_pkg::FC_LAN_SWAP]);
      end
   end

   always_comb begin
      func_state = 32'h0000_0000;
      func_state[nfp_pkg::FA_IDE]      = ide_visible;
      func_state[nfp_pkg::FA_SER]      = serial_visible;
      func_state[nfp_pkg::FA_IPMI]     = ipmi_visible;
      func_state[nfp_pkg::FA_LAN_SWAP] = func_ctrl[nfp_pkg::FC_LAN_SWAP];
   end

   // ****************************************
   // Revision key
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rev_key <= nfp_pkg::RST_REV_KEY;
      end else if (bus_wr && paddr == nfp_pkg::ADR_REVISION) begin
         rev_key <= pwdata[7:0];
      end
   end

   always_comb begin
      unique case (rev_key)
         nfp_pkg::KEY_ALT_3: revision = alt_rev_32[15:8];
         nfp_pkg::KEY_ALT_2: revision = alt_rev_32[7:0];
         nfp_pkg::KEY_ALT_1: revision = alt_rev_1;
         default:            revision = BASE_REVISION;
      endcase
   end

   // ****************************************
   // Power management data
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_select <= 4'h0;
         pm_func   <= 1'b0;
      end else if (bus_wr && paddr == nfp_pkg::ADR_PM_SELECT) begin
         pm_select <= pwdata[3:0];
         pm_func   <= pwdata[nfp_pkg::PS_FUNC];
      end
   end

   // Power word is ignored entirely when it is not trustworthy
   always_comb begin
      next_pm_data = 8'h00;
      if (sig_valid && pm_enable) begin
         unique case (pm_select)
            nfp_pkg::DS_D0_A, nfp_pkg::DS_D0_B:
               next_pm_data = lan_pwr[nfp_pkg::PW_D0 +: 8];
            nfp_pkg::DS_D3_A, nfp_pkg::DS_D3_B:
               next_pm_data = {3'h0, lan_pwr[nfp_pkg::PW_D3 +: 5]};
            nfp_pkg::DS_COMMON:
               if (!pm_func) begin
                  next_pm_data = {5'h00, lan_pwr[nfp_pkg::PW_COMMON +: 3]};
               end
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_data <= 8'h00;
      end else begin
         pm_data <= next_pm_data;
      end
   end

   // ****************************************
   // APB slave, one wait state
   // ****************************************
   always_comb begin
      addr_ok     = 1'b1;
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         nfp_pkg::ADR_FUNC_STATE: next_prdata = func_state;
         nfp_pkg::ADR_REVISION:   next_prdata = {24'h000000, revision};
         nfp_pkg::ADR_PM_SELECT:  next_prdata = {27'h0, pm_func, pm_select};
         nfp_pkg::ADR_PM_DATA:    next_prdata = {24'h000000, pm_data};
         nfp_pkg::ADR_CKSUM:      next_prdata = {31'h0, cksum_valid};
         nfp_pkg::ADR_FUNC_CTRL:  next_prdata = {16'h0000, func_ctrl};
         nfp_pkg::ADR_LAN_PWR:    next_prdata = {16'h0000, lan_pwr};
         nfp_pkg::ADR_FLASH_DET:  next_prdata = {16'h0000, cksum_valid, flash_det};
         nfp_pkg::ADR_ALT_REV_32: next_prdata = {16'h0000, alt_rev_32};
         nfp_pkg::ADR_ALT_REV_1:  next_prdata = {16'h0000, alt_rev_1, 8'h00};
         default:                 addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= !addr_ok;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ide_hide:
      assert property (load_fc |=> ide_visible == $past(nvm_data[15]))
      else $error("IDE visibility not loaded");
   chk_serial_hide:
      assert property (load_fc |=> serial_visible == $past(nvm_data[14]))
      else $error("Serial visibility not loaded");
   chk_ipmi_hide:
      assert property (load_fc |=> ipmi_visible == $past(nvm_data[13]))
      else $error("IPMI visibility not loaded");
   chk_state_mirror:
      assert property (bus_done && !pwrite && paddr == 8'h00 |->
         prdata[3:1] == $past({ipmi_visible, serial_visible, ide_visible})
         && prdata[30] == $past(func_ctrl[12]))
      else $error("Function state mirror wrong");
   chk_lan_route:
      assert property (lan_both_en && func_ctrl[12] ##1 1'b1 |->
         lan0_func && !lan1_func)
      else $error("LAN swap not applied");
   chk_int_pins:
      assert property (load_fc |=> ide_int_pin == {6'h00, $past(nvm_data[11:10])} + 8'h01
         && serial_int_pin == {6'h00, $past(nvm_data[9:8])} + 8'h01
         && ipmi_int_pin == {6'h00, $past(nvm_data[7:6])} + 8'h01)
      else $error("Interrupt pin encoding wrong");
   chk_pm_gate:
      assert property (!(sig_valid && pm_enable) |=> pm_data == 8'h00)
      else $error("Power data not gated");
   chk_pm_d0:
      assert property (sig_valid && pm_enable && pm_select == 4'h4 |=>
         pm_data == $past(lan_pwr[15:8]))
      else $error("D0 power wrong");
   chk_pm_d3:
      assert property (sig_valid && pm_enable && pm_select == 4'h7 |=>
         pm_data == {3'h0, $past(lan_pwr[4:0])})
      else $error("D3 power wrong");
   chk_pm_common:
      assert property (sig_valid && pm_enable && pm_select == 4'h8 && !pm_func |=>
         pm_data == {5'h00, $past(lan_pwr[7:5])})
      else $error("Common power wrong");
   chk_rev_key:
      assert property (psel && penable && !pready && !pwrite && paddr == 8'h04 |=>
         prdata[7:0] == ($past(rev_key) == 8'h3d ? $past(alt_rev_32[15:8]) :
         $past(rev_key) == 8'h2d ? $past(alt_rev_32[7:0]) :
         $past(rev_key) == 8'h1d ? $past(alt_rev_1) :
         BASE_REVISION))
      else $error("Revision key select wrong");
   chk_cksum_bit:
      assert property (bus_wr && paddr == 8'h10 && pwdata[0] |=> cksum_valid)
      else $error("Checksum validity not set");
   chk_apb_wait:
      assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("APB answer timing wrong");
   chk_route_plain:
      assert property (lan_both_en && !func_ctrl[12] ##1 1'b1 |->
         !lan0_func && lan1_func)
      else $error("LAN default route wrong");
   chk_cksum_load:
      assert property (nvm_load && nvm_addr == 8'h23
         && !(bus_wr && paddr == 8'h10 && pwdata[0]) |=>
         cksum_valid == $past(nvm_data[15]))
      else $error("Checksum validity not loaded");
   chk_pm_d0_low:
      assert property (sig_valid && pm_enable && pm_select == 4'h0 |=>
         pm_data == $past(lan_pwr[15:8]))
      else $error("D0 power wrong at select 0");
   chk_pm_d3_low:
      assert property (sig_valid && pm_enable && pm_select == 4'h3 |=>
         pm_data == {3'h0, $past(lan_pwr[4:0])})
      else $error("D3 power wrong at select 3");
   chk_pm_common_other:
      assert property (pm_select == 4'h8 && pm_func |=> pm_data == 8'h00)
      else $error("Common power shown on other function");
   chk_apb_err:
      assert property (psel && penable && !pready && !addr_ok |=> pslverr && prdata == 32'h0)
      else $error("Unmapped access not refused");

   cov_swap_load:  cover property (load_fc && nvm_data[12]);
   cov_pm_d0_read: cover property (bus_done && paddr == 8'h0c && pm_data != 8'h00);
   cov_alt_rev:    cover property (rev_key == 8'h3d ##1 bus_done && paddr == 8'h04);
   cov_unmapped:   cover property (bus_done && pslverr);
   cov_cksum_set:  cover property (bus_wr && paddr == 8'h10 && pwdata[0]);

endmodule
`default_nettype wire

/* sim/nfp_nvm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nfp_nvm_model (
   input  wire logic        pclk,     // Core clock
   input  wire logic        presetn,  // Async reset, active low
   input  wire logic        start,    // Begin one autoload pass
   input  wire logic        slow,     // Idle cycle between words
   output logic             busy,     // Pass in progress
   output logic             nvm_load, // Word strobe
   output logic      [7:0]  nvm_addr, // Word index
   output logic      [15:0] nvm_data  // Word data
);
   logic [15:0] mem [0:15];
   logic [7:0]  ptr;
   logic        gap;

   // Words 20h..28h; unused indices hold filler the decoder must ignore
   task automatic load_image(input logic [15:0] f, p, d, a27, a28);
      for (int i = 0; i < 16; i++) begin
         mem[i] = 16'ha5a5 ^ 16'(i);
      end
      mem[1] = {f[15:5], 5'h00};
      // Serial enable is the only serial-over-LAN path modelled
      mem[2] = p;
      mem[3] = {d[15], 15'h7fff};
      mem[7] = a27;
      mem[8] = a28;
   endtask

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         gap <= 1'b0;
         ptr <= 8'h20;
         nvm_load <= 1'b0;
         nvm_addr <= 8'h00;
         nvm_data <= 16'h0000;
      end else if (busy && !gap) begin
         nvm_load <= 1'b1;
         nvm_addr <= ptr;
         nvm_data <= mem[ptr[3:0]];
         ptr <= ptr + 8'h01;
         busy <= (ptr != 8'h28);
         gap <= slow;
      end else begin
         // Released lines scramble so stale words never look valid
         nvm_load <= 1'b0;
         nvm_addr <= ~nvm_addr;
         nvm_data <= ~nvm_data;
         gap <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            ptr <= 8'h20;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/nfp_cfg_decode_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module nfp_cfg_decode_tb;
   localparam logic [7:0] REV = 8'h5a; // Arbitrary value
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, start, slow, busy, err;
   logic        nvm_load, sig_valid, pm_enable, lan_both_en, sw;
   logic        ide_visible, serial_visible, ipmi_visible, lan0_func, lan1_func;
   logic [7:0]  paddr, nvm_addr, ide_int_pin, serial_int_pin, ipmi_int_pin, pm_data, k;
   logic [15:0] nvm_data, f, p, d, a27, a28;
   logic [31:0] pwdata, prdata, rd;
   int          errors = 0, checks_done = 0, cycles = 0, seed = 32'h5793;

   nfp_cfg_decode #(.BASE_REVISION(REV)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nvm_load(nvm_load), .nvm_addr(nvm_addr),
      .nvm_data(nvm_data), .sig_valid(sig_valid), .pm_enable(pm_enable),
      .lan_both_en(lan_both_en), .ide_visible(ide_visible), .serial_visible(serial_visible),
      .ipmi_visible(ipmi_visible), .lan0_func(lan0_func), .lan1_func(lan1_func),
      .ide_int_pin(ide_int_pin), .serial_int_pin(serial_int_pin),
      .ipmi_int_pin(ipmi_int_pin), .pm_data(pm_data));
   nfp_nvm_model nvm_u (.pclk(pclk), .presetn(presetn), .start(start), .slow(slow),
      .busy(busy), .nvm_load(nvm_load), .nvm_addr(nvm_addr), .nvm_data(nvm_data));

   always #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end

   // ****************************************
   // Expectations
   // ****************************************
   function automatic logic [31:0] fstate(input logic [15:0] w);
      return {1'b0, w[12], 26'h0, w[13], w[14], w[15], 1'b0};
   endfunction
   function automatic logic [7:0] pm_exp(input logic [15:0] w, input logic [4:0] s, input logic g);
      if (!g) return 8'h00;
      case (s)
         5'h00, 5'h04, 5'h10, 5'h14: return w[15:8];
         5'h03, 5'h07, 5'h13, 5'h17: return {3'h0, w[4:0]};
         5'h08: return {5'h00, w[7:5]};
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] rev_exp(input logic [7:0] key);
      case (key)
         8'h3d: return a27[15:8];
         8'h2d: return a27[7:0];
         8'h1d: return a28[15:8];
         default: return REV;
      endcase
   endfunction

   // ****************************************
   // Bus and report
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      presetn <= 1'b0;
      {psel, penable, pwrite, start, slow, sig_valid, pm_enable, lan_both_en} <= 8'h00;
      paddr <= 8'h00;
      pwdata <= 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK("ide_pin_rst", 8'h04, ide_int_pin)
      `CHK("ser_pin_rst", 8'h03, serial_int_pin)
      `CHK("ipmi_pin_rst", 8'h04, ipmi_int_pin)
      apb(1'b0, nfp_pkg::ADR_REVISION, 32'h0);
      `CHK("rev_rst", {24'h0, REV}, rd)
      for (int it = 0; it < 6; it++) begin
         f = (it == 0) ? 16'hffff : (it == 1) ? 16'h0000 : 16'($random(seed));
         f = {f[15:5], 5'h00};
         p = 16'($random(seed));
         d = 16'($random(seed));
         a27 = 16'($random(seed));
         a28 = 16'($random(seed));
         lan_both_en <= (it < 2) ? 1'b1 : 1'($random(seed));
         {sig_valid, pm_enable} <= (it == 0) ? 2'h3 : (it == 1) ? 2'h2 : 2'($random(seed));
         slow <= it[0];
         nvm_u.load_image(f, p, d, a27, a28);
         start <= 1'b1;
         @(posedge pclk);
         start <= 1'b0;
         do @(posedge pclk); while (busy);
         repeat (3) @(posedge pclk);
         `CHK("ide_vis", f[15], ide_visible)
         `CHK("ser_vis", f[14], serial_visible)
         `CHK("ipmi_vis", f[13], ipmi_visible)
         `CHK("ide_pin", {6'h00, f[11:10]} + 8'h01, ide_int_pin)
         `CHK("ser_pin", {6'h00, f[9:8]} + 8'h01, serial_int_pin)
         `CHK("ipmi_pin", {6'h00, f[7:6]} + 8'h01, ipmi_int_pin)
         `CHK("lan0_fn", lan_both_en & f[12], lan0_func)
         `CHK("lan1_fn", ~(lan_both_en & f[12]), lan1_func)
         apb(1'b0, nfp_pkg::ADR_FUNC_STATE, 32'h0);
         `CHK("fstate", fstate(f), rd)
         apb(1'b0, nfp_pkg::ADR_FLASH_DET, 32'h0);
         `CHK("cksum_ld", d[15], rd[15])
         for (int s = 0; s < 32; s++) begin
            apb(1'b1, nfp_pkg::ADR_PM_SELECT, 32'(s));
            repeat (2) @(posedge pclk);
            `CHK("pm_out", pm_exp(p, 5'(s), sig_valid & pm_enable), pm_data)
            apb(1'b0, nfp_pkg::ADR_PM_DATA, 32'h0);
            `CHK("pm_reg", {24'h0, pm_exp(p, 5'(s), sig_valid & pm_enable)}, rd)
         end
         for (int j = 0; j < 5; j++) begin
            k = (j == 0) ? 8'h3d : (j == 1) ? 8'h2d : (j == 2) ? 8'h1d : 8'($random(seed));
            apb(1'b1, nfp_pkg::ADR_REVISION, {24'h0, k});
            apb(1'b0, nfp_pkg::ADR_REVISION, 32'h0);
            `CHK("revision", {24'h0, rev_exp(k)}, rd)
         end
      end
      apb(1'b1, nfp_pkg::ADR_CKSUM, 32'h1);
      apb(1'b0, nfp_pkg::ADR_FLASH_DET, 32'h0);
      `CHK("cksum_sw", 1'b1, rd[15])
      apb(1'b1, nfp_pkg::ADR_FUNC_STATE, 32'hffffffff);
      `CHK("ro_err", 1'b0, err)
      apb(1'b0, nfp_pkg::ADR_FUNC_STATE, 32'h0);
      `CHK("ro_keep", fstate(f), rd)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmap_err", 1'b1, err)
      `CHK("unmap_data", 32'h0, rd)
      results();
   end
endmodule
`default_nettype wire
